// >>> motor_fault_pkg.sv
package motor_fault_pkg;
   // Register addresses on the register access port
   localparam logic [15:0] ADDR_STATUS_POWER = 16'h0201;
   localparam logic [15:0] ADDR_STATUS_SYSTEM = 16'h0202;
   localparam logic [15:0] ADDR_STATUS_MISC = 16'h0203;
   localparam logic [15:0] ADDR_RESET_COMMAND = 16'h0120;
   localparam logic [15:0] ADDR_OTP_DOWNLOAD = 16'h0121;
   // Command values
   localparam logic [7:0] CMD_SERVICE = 8'h00;
   localparam logic [7:0] CMD_CLEAR_LATCH = 8'hFF;
   localparam logic [7:0] CMD_CLEAR_CHECKSUM = 8'h55;
   localparam logic [7:0] OTP_CLEAR_LOW = 8'h00;
   localparam logic [7:0] OTP_CLEAR_HIGH = 8'hFF;
   // Bit positions, power status register
   localparam int BIT_OVERCURRENT = 0;
   localparam int BIT_SUPPLY_UV = 1;
   localparam int BIT_SUPPLY_OV = 2;
   localparam int BIT_PUMP_UV = 3;
   localparam int BIT_GATE_UV = 4;
   localparam int BIT_FET_SHORT = 5;
   localparam int BIT_EXT_OVERTEMP = 6;
   localparam int BIT_LOCKED_ROTOR = 7;
   // Bit positions, system status register
   localparam int BIT_JUNCTION_OT = 1;
   localparam int BIT_SUPERVISOR = 2;
   localparam int BIT_MOTOR_OPEN = 4;
   localparam int BIT_CHECKSUM = 5;
   localparam int BIT_PWM_FAULT = 7;
   // Bit positions, misc status register
   localparam int BIT_SPEED_CHANGE = 3;
   localparam int BIT_REG_ALL_ZERO = 4;
   localparam int BIT_OTP_ALL_ZERO = 5;
   // Timing: one tick is 0.1 ms at a 10 ns clock
   localparam int CLOCK_PERIOD_NS = 10;
   localparam int TICK_NS = 100_000;
   localparam int TICK_CYCLES = TICK_NS / CLOCK_PERIOD_NS;
   localparam int WDT_MIN_US = 1600;
   localparam int WDT_MAX_US = 102400;
   localparam int WDT_STEP_TICKS = WDT_MIN_US * 1000 / TICK_NS;
   localparam int RETRY_MS = 50;
   localparam int RETRY_TICKS = RETRY_MS * 1_000_000 / TICK_NS;
   localparam int LOCK_DETECT_MS = 400;
   localparam int LOCK_RESTART_FACTOR = 8;
   // Divide first: the full product would overflow a 32-bit int
   localparam int LOCK_STEP_TICKS =
      LOCK_DETECT_MS * LOCK_RESTART_FACTOR * (1_000_000 / TICK_NS);
   localparam int RECOVERY_STEP_MS = 100;
   localparam int RECOVERY_STEP_TICKS = RECOVERY_STEP_MS * 1_000_000 / TICK_NS;
   localparam int TIMER_W = 20;
   localparam int WDT_CNT_W = 11;
   // Motor action after a supervisor timeout or a PWM input fault
   typedef enum logic [2:0] {
      ACT_STOP = 3'h0,
      ACT_DUTY25 = 3'h1,
      ACT_DUTY50 = 3'h2,
      ACT_DUTY75 = 3'h3,
      ACT_DUTY100 = 3'h4,
      ACT_TARGET_LOW = 3'h5,
      ACT_TARGET_HIGH = 3'h6
   } action_e;
endpackage

// >>> retry_timer.sv
`timescale 1ns/10ps
// Restart delay: reloads while its condition stands, then counts ticks down
module retry_timer #(
   parameter int W = motor_fault_pkg::TIMER_W
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic start,
   input wire logic [W-1:0] load,
   output logic busy
);
   // All timer state
   typedef struct packed {
      logic [W-1:0] count;
   } timer_s;

   timer_s cur_r;
   timer_s cur_nxt;

   // Next count; the reload wins over the countdown
   always_comb
   begin
      cur_nxt = cur_r;
      if (start)
      begin
         cur_nxt.count = load;
      end
      else if (tick && (cur_r.count != '0))
      begin
         cur_nxt.count = cur_r.count - W'(1);
      end
   end

   // State register
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         cur_r <= '0;
      end
      else
      begin
         cur_r <= cur_nxt;
      end
   end

   // Busy until the delay has run out
   assign busy = (cur_r.count != '0);
endmodule

// >>> supervisor_watchdog.sv
`timescale 1ns/10ps
// Watchdog counter supervising the companion microcontroller
module supervisor_watchdog (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic enable,
   input wire logic service,
   input wire logic [5:0] periodSel,
   output logic timeout
);
   // Gray coded along off, run, expired
   typedef enum logic [1:0] {
      WD_OFF = 2'b00,
      WD_RUN = 2'b01,
      WD_EXPIRED = 2'b11
   } wd_state_e;

   typedef struct packed {
      wd_state_e state;
      logic [motor_fault_pkg::WDT_CNT_W-1:0] count;
   } wd_s;

   localparam int CW = motor_fault_pkg::WDT_CNT_W;

   wd_s cur_r;
   wd_s cur_nxt;
   logic [CW-1:0] period; // Period in ticks, 1.6 ms steps

   assign period = CW'((periodSel + 7'd1) * motor_fault_pkg::WDT_STEP_TICKS);

   // Counting and expiry
   always_comb
   begin
      cur_nxt = cur_r;
      if (!enable)
      begin
         cur_nxt.state = WD_OFF;
         cur_nxt.count = '0;
      end
      else if (service)
      begin
         cur_nxt.state = WD_RUN;
         cur_nxt.count = '0;
      end
      else
      begin
         case (cur_r.state)
            WD_OFF:
            begin
               cur_nxt.state = WD_RUN;
            end
            default:
            begin
               if (tick)
               begin
                  if (cur_r.count + CW'(1) >= period)
                  begin
                     cur_nxt.state = WD_EXPIRED;
                     cur_nxt.count = '0;
                  end
                  else
                  begin
                     cur_nxt.count = cur_r.count + CW'(1);
                  end
               end
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         cur_r <= '{state: WD_OFF, count: '0};
      end
      else
      begin
         cur_r <= cur_nxt;
      end
   end

   // Flag stands until the next service or until the watchdog is disabled
   assign timeout = (cur_r.state == WD_EXPIRED);
endmodule

// >>> motor_fault_watchdog_fault_output_pin.sv
`timescale 1ns/10ps
module motor_fault_watchdog_fault_output_pin #(
   parameter int TICK_CYCLES = motor_fault_pkg::TICK_CYCLES
) (
   input wire logic clock,
   input wire logic rst_n,
   // Register access port
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [15:0] regAddr,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   output logic regRdValid,
   // Configuration bits
   input wire logic supervisorTimerEnable,
   input wire logic [5:0] supervisorPeriodSel,
   input wire logic [2:0] timeoutActionSelect,
   input wire logic [2:0] fullDutyActionSelect,
   input wire logic [2:0] zeroDutyActionSelect,
   input wire logic faultPolaritySelect,
   input wire logic latchedOnlyFaultOutput,
   input wire logic overcurrentCheckEnable,
   input wire logic overcurrentLatch,
   input wire logic fetShortEnable,
   input wire logic fetShortLatch,
   input wire logic lockedRotorEnable,
   input wire logic lockedRotorLatch,
   input wire logic [3:0] lockedRotorTime,
   input wire logic motorOpenEnable,
   input wire logic accelCheckEnable,
   input wire logic decelCheckEnable,
   input wire logic [3:0] recoveryTimeSetting,
   // Detector conditions and motor commands
   input wire logic overcurrentDetect,
   input wire logic fetShortDetect,
   input wire logic supplyUndervoltage,
   input wire logic supplyOvervoltage,
   input wire logic pumpUndervoltage,
   input wire logic gateSupplyUndervoltage,
   input wire logic externalOvertemp,
   input wire logic junctionOvertemp,
   input wire logic lockedRotorDetect,
   input wire logic motorOpenDetect,
   input wire logic pwmInputInvalid,
   input wire logic pwmLevelHigh,
   input wire logic speedChangeDetect,
   input wire logic checksumErrorDetect,
   input wire logic registerAllZero,
   input wire logic otpAllZero,
   input wire logic motorEnable,
   input wire logic zeroCommand,
   // Power stage and fault pin
   output logic outputStageEnable,
   output logic forcedDutyValid,
   output logic [2:0] forcedAction,
   output logic faultPinOut,
   output logic faultPinOe
);
   localparam int TW = motor_fault_pkg::TIMER_W;
   localparam int PW = $clog2(TICK_CYCLES + 1);

   // All block state
   typedef struct packed {
      logic [PW-1:0] prescale;
      logic tick;
      logic ocLatched;
      logic fsLatched;
      logic lrLatched;
      logic moLatched;
      logic checksum;
      logic [7:0] rdData;
      logic rdValid;
      logic stageEn;
      logic forcedValid;
      logic [2:0] action;
      logic faultOe;
   } top_s;

   top_s cur_r;
   top_s cur_nxt;

   // Decoded writes
   logic wrReset; // Write to the reset-command register
   logic service; // Watchdog service command
   logic clearLatch; // Any latch release event
   logic clearChecksum; // Checksum clear command
   // Qualified conditions and restart delays
   logic ocCond, fsCond, lrCond, moCond, scCond;
   logic ocBusy, fsBusy, lrBusy, moBusy, scBusy;
   logic [TW-1:0] lockLoad;
   logic [TW-1:0] recoveryLoad;
   logic wdTimeout;
   // Status bytes as seen now
   logic [7:0] statusPower, statusSystem, statusMisc;
   logic anyLatched, anyFlag, blocking;
   assign wrReset = regWrEn &&
      (regAddr == motor_fault_pkg::ADDR_RESET_COMMAND);
   assign service = wrReset && (regWrData == motor_fault_pkg::CMD_SERVICE);
   assign clearLatch = !motorEnable || zeroCommand ||
      (wrReset && (regWrData == motor_fault_pkg::CMD_CLEAR_LATCH));
   assign clearChecksum =
      (wrReset && (regWrData == motor_fault_pkg::CMD_CLEAR_CHECKSUM)) ||
      (regWrEn && (regAddr == motor_fault_pkg::ADDR_OTP_DOWNLOAD) &&
       ((regWrData == motor_fault_pkg::OTP_CLEAR_LOW) ||
        (regWrData == motor_fault_pkg::OTP_CLEAR_HIGH)));

   assign ocCond = overcurrentDetect && overcurrentCheckEnable;
   assign fsCond = fetShortDetect && fetShortEnable;
   assign lrCond = lockedRotorDetect && lockedRotorEnable;
   assign moCond = motorOpenDetect && motorOpenEnable;
   assign scCond = speedChangeDetect && (accelCheckEnable || decelCheckEnable);

   assign lockLoad = TW'((lockedRotorTime + 5'd1) *
      motor_fault_pkg::LOCK_STEP_TICKS);
   assign recoveryLoad = TW'((recoveryTimeSetting + 5'd1) *
      motor_fault_pkg::RECOVERY_STEP_TICKS);

   retry_timer #(.W(TW)) ocTimer (
      .clock(clock),
      .rst_n(rst_n),
      .tick(cur_r.tick),
      .start(ocCond && !overcurrentLatch),
      .load(TW'(motor_fault_pkg::RETRY_TICKS)),
      .busy(ocBusy)
   );

   retry_timer #(.W(TW)) fsTimer (
      .clock(clock),
      .rst_n(rst_n),
      .tick(cur_r.tick),
      .start(fsCond && !fetShortLatch),
      .load(TW'(motor_fault_pkg::RETRY_TICKS)),
      .busy(fsBusy)
   );

   retry_timer #(.W(TW)) lrTimer (
      .clock(clock),
      .rst_n(rst_n),
      .tick(cur_r.tick),
      .start(lrCond && !lockedRotorLatch),
      .load(lockLoad),
      .busy(lrBusy)
   );

   retry_timer #(.W(TW)) moTimer (
      .clock(clock),
      .rst_n(rst_n),
      .tick(cur_r.tick),
      .start(moCond && !lockedRotorLatch),
      .load(lockLoad),
      .busy(moBusy)
   );

   retry_timer #(.W(TW)) scTimer (
      .clock(clock),
      .rst_n(rst_n),
      .tick(cur_r.tick),
      .start(scCond),
      .load(recoveryLoad),
      .busy(scBusy)
   );

   // timeout flags and selects the timeout action; no reset output exists
   supervisor_watchdog wdog (
      .clock(clock),
      .rst_n(rst_n),
      .tick(cur_r.tick),
      .enable(supervisorTimerEnable),
      .service(service),
      .periodSel(supervisorPeriodSel),
      .timeout(wdTimeout)
   );

   // Live status bytes; bits not kept here read as zero
   always_comb
   begin
      statusPower = 8'h00;
      statusSystem = 8'h00;
      statusMisc = 8'h00;
      // flag stands while cause, restart delay or latch stands
      statusPower[motor_fault_pkg::BIT_OVERCURRENT] =
         ocCond || ocBusy || cur_r.ocLatched;
      statusPower[motor_fault_pkg::BIT_FET_SHORT] =
         fsCond || fsBusy || cur_r.fsLatched;
      statusPower[motor_fault_pkg::BIT_LOCKED_ROTOR] =
         lrCond || lrBusy || cur_r.lrLatched;
      statusPower[motor_fault_pkg::BIT_SUPPLY_UV] = supplyUndervoltage;
      statusPower[motor_fault_pkg::BIT_SUPPLY_OV] = supplyOvervoltage;
      statusPower[motor_fault_pkg::BIT_PUMP_UV] = pumpUndervoltage;
      statusPower[motor_fault_pkg::BIT_GATE_UV] = gateSupplyUndervoltage;
      statusPower[motor_fault_pkg::BIT_EXT_OVERTEMP] = externalOvertemp;
      statusSystem[motor_fault_pkg::BIT_JUNCTION_OT] = junctionOvertemp;
      statusSystem[motor_fault_pkg::BIT_SUPERVISOR] = wdTimeout;
      statusSystem[motor_fault_pkg::BIT_MOTOR_OPEN] =
         moCond || moBusy || cur_r.moLatched;
      statusSystem[motor_fault_pkg::BIT_CHECKSUM] = cur_r.checksum;
      statusSystem[motor_fault_pkg::BIT_PWM_FAULT] = pwmInputInvalid;
      statusMisc[motor_fault_pkg::BIT_SPEED_CHANGE] = scCond || scBusy;
      statusMisc[motor_fault_pkg::BIT_REG_ALL_ZERO] = registerAllZero;
      statusMisc[motor_fault_pkg::BIT_OTP_ALL_ZERO] = otpAllZero;
   end

   assign anyLatched = cur_r.ocLatched || cur_r.fsLatched ||
      cur_r.lrLatched || cur_r.moLatched;
   assign anyFlag = (statusPower != 8'h00) || (statusSystem != 8'h00) ||
      (statusMisc != 8'h00);
   // all-zero warnings left out of shutdown
   assign blocking = (statusPower != 8'h00) ||
      statusSystem[motor_fault_pkg::BIT_JUNCTION_OT] ||
      statusSystem[motor_fault_pkg::BIT_MOTOR_OPEN] ||
      statusSystem[motor_fault_pkg::BIT_CHECKSUM] ||
      statusMisc[motor_fault_pkg::BIT_SPEED_CHANGE];

   // Next state of the whole block
   always_comb
   begin
      cur_nxt = cur_r;
      // Tick prescaler, one pulse per 0.1 ms
      cur_nxt.tick = 1'b0;
      if (cur_r.prescale == PW'(TICK_CYCLES - 1))
      begin
         cur_nxt.prescale = '0;
         cur_nxt.tick = 1'b1;
      end
      else
      begin
         cur_nxt.prescale = cur_r.prescale + PW'(1);
      end
      // release first, a new event then wins
      if (clearLatch)
      begin
         cur_nxt.ocLatched = 1'b0;
         cur_nxt.fsLatched = 1'b0;
         cur_nxt.lrLatched = 1'b0;
         cur_nxt.moLatched = 1'b0;
      end
      // latch when its latch bit set
      if (ocCond && overcurrentLatch)
      begin
         cur_nxt.ocLatched = 1'b1;
      end
      if (fsCond && fetShortLatch)
      begin
         cur_nxt.fsLatched = 1'b1;
      end
      if (lrCond && lockedRotorLatch)
      begin
         cur_nxt.lrLatched = 1'b1;
      end
      if (moCond && lockedRotorLatch)
      begin
         cur_nxt.moLatched = 1'b1;
      end
      // clear, but a new error wins
      if (clearChecksum)
      begin
         cur_nxt.checksum = 1'b0;
      end
      if (checksumErrorDetect)
      begin
         cur_nxt.checksum = 1'b1;
      end
      cur_nxt.rdValid = regRdEn;
      if (!regRdEn)
      begin
         cur_nxt.rdData = cur_r.rdData;
      end
      else if (regAddr == motor_fault_pkg::ADDR_STATUS_POWER)
      begin
         cur_nxt.rdData = statusPower;
      end
      else if (regAddr == motor_fault_pkg::ADDR_STATUS_SYSTEM)
      begin
         cur_nxt.rdData = statusSystem;
      end
      else if (regAddr == motor_fault_pkg::ADDR_STATUS_MISC)
      begin
         cur_nxt.rdData = statusMisc;
      end
      else
      begin
         // Unmapped address reads zero
         cur_nxt.rdData = 8'h00;
      end
      // Power stage: errors stop it outright
      cur_nxt.forcedValid = 1'b0;
      cur_nxt.action = motor_fault_pkg::ACT_STOP;
      if (blocking)
      begin
         cur_nxt.stageEn = 1'b0;
      end
      else if (wdTimeout)
      begin
         cur_nxt.action = timeoutActionSelect;
         cur_nxt.forcedValid =
            (timeoutActionSelect != motor_fault_pkg::ACT_STOP);
         cur_nxt.stageEn = cur_nxt.forcedValid;
      end
      else if (pwmInputInvalid)
      begin
         cur_nxt.action = pwmLevelHigh ? fullDutyActionSelect :
            zeroDutyActionSelect;
         cur_nxt.forcedValid =
            (cur_nxt.action != motor_fault_pkg::ACT_STOP);
         cur_nxt.stageEn = cur_nxt.forcedValid;
      end
      else
      begin
         cur_nxt.stageEn = 1'b1;
      end
      cur_nxt.faultOe = (latchedOnlyFaultOutput ? anyLatched : anyFlag) ^
         faultPolaritySelect;
   end

   // State register; reset also releases every latch
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         cur_r <= '0;
      end
      else
      begin
         cur_r <= cur_nxt;
      end
   end

   // Outputs straight from flops
   assign regRdData = cur_r.rdData;
   assign regRdValid = cur_r.rdValid;
   assign outputStageEnable = cur_r.stageEn;
   assign forcedDutyValid = cur_r.forcedValid;
   assign forcedAction = cur_r.action;
   // Open drain: only ever pulls low
   assign faultPinOut = 1'b0;
   assign faultPinOe = cur_r.faultOe;
endmodule

// >>> motor_fault_mcu_model.sv
`timescale 1ns/10ps
// Companion controller: register accesses and the fault interrupt line
module motor_fault_mcu_model (
   input wire logic clock,
   input wire logic faultPinOe,
   input wire logic regRdValid,
   input wire logic [7:0] regRdData,
   output logic regWrEn,
   output logic regRdEn,
   output logic [15:0] regAddr,
   output logic [7:0] regWrData,
   output logic faultLine
);
   // Pulled up; low only while the device pulls the pin
   assign faultLine = !faultPinOe;
   initial
   begin
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      regAddr = 16'hFFFF;
      regWrData = 8'h00;
   end
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clock);
      regWrEn <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clock);
      regWrEn <= 1'b0;
      // Released lines show the inverse, not the old value
      regAddr <= ~a;
      regWrData <= ~d;
   endtask
   // Read strobe, data taken while the answer stands
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clock);
      regRdEn <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRdEn <= 1'b0;
      regAddr <= ~a;
      @(negedge clock);
      d = regRdValid ? regRdData : 8'hxx;
   endtask
endmodule

// >>> motor_fault_watchdog_fault_output_pin_sva.sv
`timescale 1ns/10ps
// Port-level checks of the fault block
module motor_fault_watchdog_fault_output_pin_sva (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [15:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic [7:0] regRdData,
   input wire logic regRdValid,
   input wire logic supervisorTimerEnable,
   input wire logic latchedOnlyFaultOutput,
   input wire logic faultPolaritySelect,
   input wire logic overcurrentCheckEnable,
   input wire logic overcurrentDetect,
   input wire logic supplyUndervoltage,
   input wire logic externalOvertemp,
   input wire logic pwmInputInvalid,
   input wire logic registerAllZero,
   input wire logic outputStageEnable,
   input wire logic forcedDutyValid,
   input wire logic faultPinOut,
   input wire logic faultPinOe
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   read_answer_a: assert property (regRdEn |=> regRdValid)
      else $error("read not answered");
   read_once_a: assert property (!regRdEn |=> !regRdValid)
      else $error("read answer without read");
   open_drain_a: assert property (faultPinOut == 1'b0)
      else $error("fault pin driven high");
   supply_stop_a: assert property (supplyUndervoltage[*3] |->
      !outputStageEnable) else $error("stage on in undervoltage");
   temp_stop_a: assert property (externalOvertemp[*3] |->
      !outputStageEnable) else $error("stage on in overtemp");
   oc_stop_a: assert property ((overcurrentDetect &&
      overcurrentCheckEnable)[*3] |-> !outputStageEnable)
      else $error("stage on in overcurrent");
   warn_pin_a: assert property ((registerAllZero &&
      !latchedOnlyFaultOutput && !faultPolaritySelect)[*3] |-> faultPinOe)
      else $error("warning missing on pin");
   wdt_off_a: assert property ((!supervisorTimerEnable &&
      !pwmInputInvalid)[*3] |-> !forcedDutyValid)
      else $error("timeout action while disabled");
   service_a: assert property ((regWrEn && regWrData == 8'h00 &&
      regAddr == motor_fault_pkg::ADDR_RESET_COMMAND && forcedDutyValid
      && supervisorTimerEnable && !pwmInputInvalid) |-> ##[1:3]
      !forcedDutyValid) else $error("service did not end action");
   unmapped_a: assert property (regRdEn && regAddr == 16'h0300
      |=> regRdData == 8'h00) else $error("unmapped read not zero");
   cover property (regRdValid && regRdData != 8'h00);
   cover property ($rose(forcedDutyValid));
   cover property ($fell(outputStageEnable));
endmodule
bind motor_fault_watchdog_fault_output_pin motor_fault_watchdog_fault_output_pin_sva u_sva (.*);

// >>> tb_motor_fault_watchdog_fault_output_pin.sv
`timescale 1ns/10ps
module tb_motor_fault_watchdog_fault_output_pin;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic regWrEn, regRdEn, regRdValid, faultLine;
   logic [15:0] regAddr;
   logic [7:0] regWrData, regRdData;
   logic supervisorTimerEnable = 0, faultPolaritySelect = 0;
   logic latchedOnlyFaultOutput = 0, motorEnable = 1, zeroCommand = 0;
   logic checksumErrorDetect = 0, latch = 1, chkEn = 1;
   logic [5:0] supervisorPeriodSel = 6'h00;
   logic [2:0] timeoutActionSelect = 3'h2;
   logic [13:0] det = 14'h0000;
   logic outputStageEnable, forcedDutyValid, faultPinOut, faultPinOe;
   logic [2:0] forcedAction;
   int err_count = 0, checked = 0, cycles = 0;
   // Register and bit of each detector in det, and whether it blocks
   int ra[14] = '{1, 1, 1, 1, 1, 1, 1, 1, 2, 2, 3, 3, 3, 2};
   int rb[14] = '{0, 1, 2, 3, 4, 5, 6, 7, 1, 4, 3, 4, 5, 7};
   localparam logic [13:0] RUNS = 14'h3800;
   wire overcurrentDetect = det[0], supplyUndervoltage = det[1];
   wire supplyOvervoltage = det[2], pumpUndervoltage = det[3];
   wire gateSupplyUndervoltage = det[4], fetShortDetect = det[5];
   wire externalOvertemp = det[6], lockedRotorDetect = det[7];
   wire junctionOvertemp = det[8], motorOpenDetect = det[9];
   wire speedChangeDetect = det[10], registerAllZero = det[11];
   wire otpAllZero = det[12], pwmInputInvalid = det[13];
   wire overcurrentLatch = latch, fetShortLatch = latch;
   wire lockedRotorLatch = latch, overcurrentCheckEnable = chkEn;
   wire fetShortEnable = chkEn, lockedRotorEnable = chkEn;
   wire motorOpenEnable = chkEn, accelCheckEnable = chkEn;
   wire decelCheckEnable = chkEn;
   wire [2:0] zeroDutyActionSelect = timeoutActionSelect;
   wire [2:0] fullDutyActionSelect = 3'h0;
   // PWM stuck high rides on the register all-zero warning
   wire pwmLevelHigh = det[11];
   wire [3:0] lockedRotorTime = 4'h0, recoveryTimeSetting = 4'h0;
   // Short tick so retry and recovery delays are a few thousand cycles at most; the locked-rotor delay is 64000 cycles
   motor_fault_watchdog_fault_output_pin #(.TICK_CYCLES(2)) u_dut (.*);
   motor_fault_mcu_model u_mcu (.*);
   always #5 clock = ~clock;
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         err_count++;
         end_of_test();
      end
   end
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      checked++;
      if (g !== e)
      begin
         err_count++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rdchk(logic [15:0] a, logic [7:0] e);
      logic [7:0] d;
      u_mcu.rd(a, d);
      chk("status", e, d);
   endtask
   task automatic pins(logic oe, logic st);
      @(negedge clock);
      chk("pin", {7'h00, oe}, {7'h00, faultPinOe});
      chk("stage", {7'h00, st}, {7'h00, outputStageEnable});
      chk("line", {7'h00, !oe}, {7'h00, faultLine});
   endtask
   // Apply detectors and pin modes, then judge pin and stage
   task automatic step(logic [13:0] dv, logic p, logic lo, logic eo,
      logic es);
      @(posedge clock);
      det <= dv;
      faultPolaritySelect <= p;
      latchedOnlyFaultOutput <= lo;
      repeat (4) @(posedge clock);
      pins(eo, es);
   endtask
   task automatic t_reset();
      repeat (3) @(posedge clock);
      for (int a = 1; a < 4; a++)
         rdchk(16'h0200 + 16'(a), 8'h00);
      rdchk(16'h0300, 8'h00);
      pins(1'b0, 1'b1);
      $display("test reset done");
   endtask
   task automatic t_flags();
      for (int i = 0; i < 14; i++)
      begin
         step(14'h0001 << i, 1'b0, 1'b0, 1'b1, RUNS[i]);
         rdchk(16'h0200 + 16'(ra[i]), 8'(1 << rb[i]));
         @(posedge clock);
         det <= 14'h0000;
         u_mcu.wr(motor_fault_pkg::ADDR_RESET_COMMAND, 8'hFF);
         repeat (2100) @(posedge clock);
         rdchk(16'h0200 + 16'(ra[i]), 8'h00);
      end
      $display("test flags done");
   endtask
   task automatic t_pin();
      step(14'h0000, 1'b1, 1'b0, 1'b1, 1'b1);
      step(14'h0002, 1'b1, 1'b0, 1'b0, 1'b0);
      step(14'h0002, 1'b1, 1'b1, 1'b1, 1'b0);
      step(14'h0800, 1'b1, 1'b0, 1'b0, 1'b1);
      step(14'h2800, 1'b0, 1'b0, 1'b1, 1'b0);
      step(14'h0001, 1'b0, 1'b1, 1'b1, 1'b0);
      step(14'h0000, 1'b0, 1'b1, 1'b1, 1'b0);
      u_mcu.wr(motor_fault_pkg::ADDR_RESET_COMMAND, 8'hFF);
      step(14'h0000, 1'b0, 1'b0, 1'b0, 1'b1);
      $display("test pin done");
   endtask
   task automatic t_retry();
      @(posedge clock);
      chkEn <= 1'b0;
      step(14'h0001, 1'b0, 1'b0, 1'b0, 1'b1);
      @(posedge clock);
      chkEn <= 1'b1;
      latch <= 1'b0;
      step(14'h0001, 1'b0, 1'b0, 1'b1, 1'b0);
      step(14'h0000, 1'b0, 1'b0, 1'b1, 1'b0);
      repeat (983) @(posedge clock);
      pins(1'b1, 1'b0);
      repeat (20) @(posedge clock);
      pins(1'b0, 1'b1);
      @(posedge clock);
      latch <= 1'b1;
      for (int m = 0; m < 3; m++)
      begin
         step(14'h0001, 1'b0, 1'b0, 1'b1, 1'b0);
         step(14'h0000, 1'b0, 1'b0, 1'b1, 1'b0);
         repeat (1100) @(posedge clock);
         pins(1'b1, 1'b0);
         @(posedge clock);
         if (m == 0)
            u_mcu.wr(motor_fault_pkg::ADDR_RESET_COMMAND, 8'hFF);
         else if (m == 1)
            motorEnable <= 1'b0;
         else
            zeroCommand <= 1'b1;
         @(posedge clock);
         motorEnable <= 1'b1;
         zeroCommand <= 1'b0;
         step(14'h0000, 1'b0, 1'b0, 1'b0, 1'b1);
      end
      $display("test retry done");
   endtask
   task automatic t_csum();
      for (int m = 0; m < 3; m++)
      begin
         @(posedge clock);
         checksumErrorDetect <= 1'b1;
         @(posedge clock);
         checksumErrorDetect <= 1'b0;
         step(14'h0000, 1'b0, 1'b0, 1'b1, 1'b0);
         rdchk(motor_fault_pkg::ADDR_STATUS_SYSTEM, 8'h20);
         u_mcu.wr(16'h0120 + 16'(m > 0), m == 0 ? 8'h55 : {8{m == 2}});
         rdchk(motor_fault_pkg::ADDR_STATUS_SYSTEM, 8'h00);
         pins(1'b0, 1'b1);
      end
      $display("test checksum done");
   endtask
   task automatic t_wdt();
      for (int s = 0; s < 2; s++)
      begin
         @(posedge clock);
         supervisorPeriodSel <= 6'(s);
         supervisorTimerEnable <= 1'b0;
         @(posedge clock);
         supervisorTimerEnable <= 1'b1;
         repeat (32 * (s + 1) - 8) @(posedge clock);
         rdchk(motor_fault_pkg::ADDR_STATUS_SYSTEM, 8'h00);
         repeat (12) @(posedge clock);
         rdchk(motor_fault_pkg::ADDR_STATUS_SYSTEM, 8'h04);
      end
      for (int a = 0; a < 7; a++)
      begin
         @(posedge clock);
         timeoutActionSelect <= 3'(a);
         repeat (4) @(posedge clock);
         pins(1'b1, a != 0);
         chk("forced", {7'h00, a != 0}, {7'h00, forcedDutyValid});
         if (a != 0)
            chk("action", 8'(a), {5'h00, forcedAction});
      end
      @(posedge clock);
      timeoutActionSelect <= 3'h2;
      repeat (5)
      begin
         u_mcu.wr(motor_fault_pkg::ADDR_RESET_COMMAND, 8'h00);
         repeat (40) @(posedge clock);
      end
      rdchk(motor_fault_pkg::ADDR_STATUS_SYSTEM, 8'h00);
      @(posedge clock);
      supervisorTimerEnable <= 1'b0;
      repeat (200) @(posedge clock);
      rdchk(motor_fault_pkg::ADDR_STATUS_SYSTEM, 8'h00);
      pins(1'b0, 1'b1);
      $display("test watchdog done");
   endtask
   task automatic end_of_test();
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      t_reset();
      t_flags();
      t_pin();
      t_retry();
      t_csum();
      t_wdt();
      end_of_test();
   end
endmodule
